// file: opcd_core.v
// Optical port pin conditioning, transmit carrier and energy pulse shaping.
// Assumes synchronous inputs on mclk and a master that never needs waits.
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ns
`include "opcd_defs.vh"

// One energy pulse channel: pacing queue and width limiter
module opcd_pulse_chan #(
    parameter QW = 4
) (
    input  wire       mclk,
    input  wire       reset,
    input  wire       issue,
    input  wire       paced,
    input  wire       pace_tick,
    input  wire       unit_tick,
    input  wire [7:0] max_width,
    output reg        active_reg,
    output reg [QW-1:0] pending_reg
);
    reg  [8:0]    width_reg;
    wire          start;
    wire          q_full;
    wire          q_inc;
    wire          q_dec;
    wire [8:0]    limit;

    assign q_full = &pending_reg;
    assign q_inc  = paced & issue & ~q_full;
    assign q_dec  = paced & pace_tick & (pending_reg != {QW{1'b0}});
    assign start  = paced ? q_dec : issue;
    assign limit  = {max_width, 1'b0};

    // Queue of pulses waiting for a pacing slot; arrival and release cancel
    always @(posedge mclk) begin
        if (reset) begin
            pending_reg <= {QW{1'b0}};
        end else if (~paced) begin
            pending_reg <= {QW{1'b0}};
        end else if (q_inc & ~q_dec) begin
            pending_reg <= pending_reg + 1'b1;
        end else if (q_dec & ~q_inc) begin
            pending_reg <= pending_reg - 1'b1;
        end
    end

    // Pulse active state and width count in time units
    always @(posedge mclk) begin
        if (reset) begin
            active_reg <= 1'b0;
            width_reg  <= 9'h000;
        end else if (max_width == `OPCD_MAXW_OFF) begin
            width_reg <= 9'h000;
            if (start) begin
                active_reg <= ~active_reg;
            end
        end else if (start) begin
            active_reg <= 1'b1;
            width_reg  <= 9'h000;
        end else if (active_reg & unit_tick) begin
            if (width_reg >= limit) begin
                active_reg <= 1'b0;
            end else begin
                width_reg <= width_reg + 9'h001;
            end
        end
    end
endmodule

// Top of the block
module opcd_core #(
    parameter CARRIER_DIV = 32,
    parameter QW          = 4
) (
    input  wire       mclk,
    input  wire       reset,
    input  wire [15:0] reg_addr,
    input  wire [7:0] reg_wdata,
    input  wire       reg_wr,
    input  wire       reg_rd,
    output reg  [7:0] reg_rdata,
    input  wire       rx_comp_in,
    input  wire       rx_pin_level,
    input  wire       gio1_drive,
    input  wire       gio1_drive_en,
    output reg        rx_comp_enable,
    output reg        uart_rxd,
    output reg        general_io_one_in,
    output reg        rx_pin_out,
    output reg        rx_pin_oe,
    input  wire       uart_txd,
    input  wire       general_io_two,
    output reg        optical_transmit_pin,
    input  wire       ce_real_issue,
    input  wire       ce_reactive_issue,
    output reg        real_energy_pulse,
    output reg        reactive_energy_pulse
);
    localparam        SAMPLE_CYC = `OPCD_SAMPLE_CYC;
    localparam        UNIT_CYC   = `OPCD_UNIT_CYC;

    reg        pulse_polarity_invert_reg;
    reg [1:0]  optical_tx_source_select_reg;
    reg [1:0]  carrier_duty_select_reg;
    reg        optical_rx_as_gpio_reg;
    reg        optical_rx_invert_reg;
    reg        optical_tx_modulate_enable_reg;
    reg        optical_tx_invert_reg;
    reg [7:0]  pulse_max_width_reg;
    reg [7:0]  pulse_fifo_interval_reg;
    reg [11:0] sample_cnt_reg;
    reg [7:0]  unit_cnt_reg;
    reg [7:0]  intv_cnt_reg;
    reg        sample_tick_reg;
    reg        pace_tick_reg;
    reg [15:0] carrier_cnt_reg;
    reg [7:0]  rdata_next;
    reg        tx_src;
    wire       paced;
    wire       unit_tick;
    wire       real_active;
    wire       react_active;
    wire [QW-1:0] real_pend;
    wire [QW-1:0] react_pend;
    wire [15:0] low_len;
    wire       carrier;
    wire       tx_post;
    wire       real_level;
    wire       react_level;

    // Register writes
    always @(posedge mclk) begin
        if (reset) begin
            pulse_polarity_invert_reg      <= `OPCD_RST_POL;
            optical_tx_source_select_reg   <= `OPCD_RST_TXSEL;
            carrier_duty_select_reg        <= `OPCD_RST_DUTY;
            optical_rx_as_gpio_reg         <= `OPCD_RST_BIT;
            optical_rx_invert_reg          <= `OPCD_RST_BIT;
            optical_tx_modulate_enable_reg <= `OPCD_RST_BIT;
            optical_tx_invert_reg          <= `OPCD_RST_BIT;
            pulse_max_width_reg            <= `OPCD_RST_MAXW;
            pulse_fifo_interval_reg        <= `OPCD_RST_INTV;
        end else if (reg_wr) begin
            if (reg_addr == `OPCD_ADDR_PLS_POL) begin
                pulse_polarity_invert_reg <= reg_wdata[`OPCD_POL_BIT];
            end else if (reg_addr == `OPCD_ADDR_TX_CFG) begin
                optical_tx_source_select_reg <= reg_wdata[`OPCD_TXSEL_HI:`OPCD_TXSEL_LO];
                carrier_duty_select_reg      <= reg_wdata[`OPCD_DUTY_HI:`OPCD_DUTY_LO];
            end else if (reg_addr == `OPCD_ADDR_OPT_CFG) begin
                optical_rx_as_gpio_reg         <= reg_wdata[`OPCD_RXGPIO_BIT];
                optical_rx_invert_reg          <= reg_wdata[`OPCD_RXINV_BIT];
                optical_tx_modulate_enable_reg <= reg_wdata[`OPCD_TXMOD_BIT];
                optical_tx_invert_reg          <= reg_wdata[`OPCD_TXINV_BIT];
            end else if (reg_addr == `OPCD_ADDR_MAXW) begin
                pulse_max_width_reg <= reg_wdata;
            end else if (reg_addr == `OPCD_ADDR_INTV) begin
                pulse_fifo_interval_reg <= reg_wdata;
            end
        end
    end

    // Read data mux; unmapped addresses and unused bits read zero
    always @* begin
        rdata_next = 8'h00;
        if (reg_addr == `OPCD_ADDR_PLS_POL) begin
            rdata_next[`OPCD_POL_BIT] = pulse_polarity_invert_reg;
        end else if (reg_addr == `OPCD_ADDR_TX_CFG) begin
            rdata_next[`OPCD_TXSEL_HI:`OPCD_TXSEL_LO] = optical_tx_source_select_reg;
            rdata_next[`OPCD_DUTY_HI:`OPCD_DUTY_LO]   = carrier_duty_select_reg;
        end else if (reg_addr == `OPCD_ADDR_OPT_CFG) begin
            rdata_next[`OPCD_RXGPIO_BIT] = optical_rx_as_gpio_reg;
            rdata_next[`OPCD_RXINV_BIT]  = optical_rx_invert_reg;
            rdata_next[`OPCD_TXMOD_BIT]  = optical_tx_modulate_enable_reg;
            rdata_next[`OPCD_TXINV_BIT]  = optical_tx_invert_reg;
        end else if (reg_addr == `OPCD_ADDR_MAXW) begin
            rdata_next = pulse_max_width_reg;
        end else if (reg_addr == `OPCD_ADDR_INTV) begin
            rdata_next = pulse_fifo_interval_reg;
        end else if (reg_addr == `OPCD_ADDR_STATUS) begin
            rdata_next = {react_active, real_active, 6'h00};
            rdata_next[5:3] = (react_pend != {QW{1'b0}}) ? 3'h1 : 3'h0;
            rdata_next[2:0] = (real_pend != {QW{1'b0}}) ? 3'h1 : 3'h0;
        end
    end

    // Read data stands only in the cycle after the strobe
    always @(posedge mclk) begin
        if (reset) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata <= rdata_next;
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    // Sample period tick, the time unit when no interval is set
    always @(posedge mclk) begin
        if (reset) begin
            sample_cnt_reg  <= 12'h000;
            sample_tick_reg <= 1'b0;
        end else if (sample_cnt_reg == SAMPLE_CYC - 12'h001) begin
            sample_cnt_reg  <= 12'h000;
            sample_tick_reg <= 1'b1;
        end else begin
            sample_cnt_reg  <= sample_cnt_reg + 12'h001;
            sample_tick_reg <= 1'b0;
        end
    end

    // Interval tick: interval setting times the base unit
    always @(posedge mclk) begin
        if (reset || !paced) begin
            unit_cnt_reg  <= 8'h00;
            intv_cnt_reg  <= 8'h00;
            pace_tick_reg <= 1'b0;
        end else if (unit_cnt_reg == UNIT_CYC - 8'h01) begin
            unit_cnt_reg <= 8'h00;
            if (intv_cnt_reg >= pulse_fifo_interval_reg - 8'h01) begin
                intv_cnt_reg  <= 8'h00;
                pace_tick_reg <= 1'b1;
            end else begin
                intv_cnt_reg  <= intv_cnt_reg + 8'h01;
                pace_tick_reg <= 1'b0;
            end
        end else begin
            unit_cnt_reg  <= unit_cnt_reg + 8'h01;
            pace_tick_reg <= 1'b0;
        end
    end

    assign paced     = (pulse_fifo_interval_reg != 8'h00);
    assign unit_tick = paced ? pace_tick_reg : sample_tick_reg;

    // Pacing queue depth suits the interval software programs
    opcd_pulse_chan #(.QW(QW)) u_real (
        .mclk        (mclk),
        .reset       (reset),
        .issue       (ce_real_issue),
        .paced       (paced),
        .pace_tick   (pace_tick_reg),
        .unit_tick   (unit_tick),
        .max_width   (pulse_max_width_reg),
        .active_reg  (real_active),
        .pending_reg (real_pend)
    );

    opcd_pulse_chan #(.QW(QW)) u_react (
        .mclk        (mclk),
        .reset       (reset),
        .issue       (ce_reactive_issue),
        .paced       (paced),
        .pace_tick   (pace_tick_reg),
        .unit_tick   (unit_tick),
        .max_width   (pulse_max_width_reg),
        .active_reg  (react_active),
        .pending_reg (react_pend)
    );

    // Pin levels of the pulses, active low unless inverted
    assign real_level  = pulse_polarity_invert_reg ? real_active : ~real_active;
    assign react_level = pulse_polarity_invert_reg ? react_active : ~react_active;

    always @(posedge mclk) begin
        if (reset) begin
            real_energy_pulse     <= 1'b1;
            reactive_energy_pulse <= 1'b1;
        end else begin
            real_energy_pulse     <= real_level;
            reactive_energy_pulse <= react_level;
        end
    end

    // Carrier divider; low part is the period shifted right by the duty code plus one
    always @(posedge mclk) begin
        if (reset) begin
            carrier_cnt_reg <= 16'h0000;
        end else if (carrier_cnt_reg == CARRIER_DIV - 1) begin
            carrier_cnt_reg <= 16'h0000;
        end else begin
            carrier_cnt_reg <= carrier_cnt_reg + 16'h0001;
        end
    end

    assign low_len = CARRIER_DIV[15:0] >> ({1'b0, carrier_duty_select_reg} + 3'b001);
    assign carrier = (carrier_cnt_reg >= low_len);

    // Transmit source selection
    always @* begin
        case (optical_tx_source_select_reg)
            `OPCD_TX_UART: tx_src = uart_txd;
            `OPCD_TX_GIO2: tx_src = general_io_two;
            `OPCD_TX_REAL: tx_src = real_level;
            default:       tx_src = react_level;
        endcase
    end

    assign tx_post = tx_src ^ optical_tx_invert_reg;

    // Modulate only where the inverted signal is low
    always @(posedge mclk) begin
        if (reset) begin
            optical_transmit_pin <= 1'b1;
        end else if (optical_tx_modulate_enable_reg && !tx_post) begin
            optical_transmit_pin <= carrier;
        end else begin
            optical_transmit_pin <= tx_post;
        end
    end

    // Receive pin: comparator path or general IO one
    always @(posedge mclk) begin
        if (reset) begin
            rx_comp_enable    <= 1'b1;
            uart_rxd          <= 1'b1;
            general_io_one_in <= 1'b0;
            rx_pin_out        <= 1'b0;
            rx_pin_oe         <= 1'b0;
        end else begin
            rx_comp_enable    <= ~optical_rx_as_gpio_reg;
            uart_rxd          <= optical_rx_as_gpio_reg ? 1'b1
                                 : (rx_comp_in ^ optical_rx_invert_reg);
            general_io_one_in <= optical_rx_as_gpio_reg & rx_pin_level;
            rx_pin_out        <= gio1_drive;
            rx_pin_oe         <= optical_rx_as_gpio_reg & gio1_drive_en;
        end
    end
endmodule

// file: opcd_defs.vh
// Constants for the optical port and energy pulse conditioning block.
// Assumes byte-wide registers reached through a plain strobe port.
`ifndef OPCD_DEFS_VH
`define OPCD_DEFS_VH

// Register offsets
`define OPCD_ADDR_PLS_POL    16'h2004
`define OPCD_ADDR_TX_CFG     16'h2007
`define OPCD_ADDR_OPT_CFG    16'h2008
`define OPCD_ADDR_MAXW       16'h2080
`define OPCD_ADDR_INTV       16'h2081
`define OPCD_ADDR_STATUS     16'h2082

// Field positions
`define OPCD_POL_BIT         6
`define OPCD_TXSEL_HI        7
`define OPCD_TXSEL_LO        6
`define OPCD_DUTY_HI         1
`define OPCD_DUTY_LO         0
`define OPCD_RXGPIO_BIT      5
`define OPCD_RXINV_BIT       4
`define OPCD_TXMOD_BIT       1
`define OPCD_TXINV_BIT       0

// Reset values
`define OPCD_RST_POL         1'b0
`define OPCD_RST_TXSEL       2'b00
`define OPCD_RST_DUTY        2'b00
`define OPCD_RST_BIT         1'b0
`define OPCD_RST_MAXW        8'hff
`define OPCD_RST_INTV        8'h00

// Transmit source codes
`define OPCD_TX_UART         2'b00
`define OPCD_TX_GIO2         2'b01
`define OPCD_TX_REAL         2'b10
`define OPCD_TX_REACT        2'b11

// Width value that turns the limiter off
`define OPCD_MAXW_OFF        8'hff

// Timing
`define OPCD_CLK_HZ          10000000
`define OPCD_SAMPLE_NS       397000
`define OPCD_SAMPLE_CYC      ((`OPCD_SAMPLE_NS * (`OPCD_CLK_HZ / 1000000) + 999) / 1000)
`define OPCD_UNIT_NS         4900
`define OPCD_UNIT_CYC        ((`OPCD_UNIT_NS * (`OPCD_CLK_HZ / 1000000) + 999) / 1000)

`endif

// file: opcd_core_monitor.sv
// Checker bound to opcd_core: pin paths, read slot and prompt pulses.
// Assumes it sees only core ports and shadows the register writes.
`timescale 1ns/1ns
module opcd_core_monitor #(
    parameter CARRIER_DIV = 32,
    parameter QW          = 4
) (
    input logic        mclk,
    input logic        reset,
    input logic [15:0] reg_addr,
    input logic [7:0]  reg_wdata,
    input logic        reg_wr,
    input logic        reg_rd,
    input logic [7:0]  reg_rdata,
    input logic        rx_comp_in,
    input logic        rx_pin_level,
    input logic        gio1_drive_en,
    input logic        rx_comp_enable,
    input logic        uart_rxd,
    input logic        general_io_one_in,
    input logic        rx_pin_oe,
    input logic        uart_txd,
    input logic        general_io_two,
    input logic        optical_transmit_pin,
    input logic        ce_real_issue,
    input logic        real_energy_pulse
);
    logic [7:0] cfg_reg;
    logic [7:0] sel_reg;
    logic [7:0] intv_reg;
    logic       pol_reg;
    logic       post;
    // Transmit source after inversion
    assign post = (sel_reg[6] ? general_io_two : uart_txd) ^ cfg_reg[0];
    // Shadow copies of written configuration
    always @(posedge mclk) begin
        if (reset) begin
            cfg_reg  <= 8'h00;
            sel_reg  <= 8'h00;
            intv_reg <= 8'h00;
            pol_reg  <= 1'b0;
        end else if (reg_wr) begin
            if (reg_addr == 16'h2008) cfg_reg <= reg_wdata;
            if (reg_addr == 16'h2007) sel_reg <= reg_wdata;
            if (reg_addr == 16'h2081) intv_reg <= reg_wdata;
            if (reg_addr == 16'h2004) pol_reg <= reg_wdata[6];
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);
    // Prompt pulse: issue on an idle pin, pin answers on the second edge
    sequence s_issue;
        ce_real_issue && !$past(ce_real_issue) && intv_reg == 8'h00 && !reg_wr
            && real_energy_pulse != pol_reg;
    endsequence
    sequence s_answer;
        real_energy_pulse != pol_reg ##1 real_energy_pulse == pol_reg;
    endsequence
    property p_pls_fast; s_issue |-> ##1 s_answer; endproperty
    property p_rd_idle; !$past(reg_rd) |-> reg_rdata == 8'h00; endproperty
    property p_rx_uart;
        !$past(reset) && rx_comp_enable |-> uart_rxd == $past(rx_comp_in ^ cfg_reg[4]);
    endproperty
    property p_rx_mode; !$past(reset) |-> rx_comp_enable == !$past(cfg_reg[5]); endproperty
    property p_rx_oe; !$past(reset) |-> rx_pin_oe == $past(cfg_reg[5] & gio1_drive_en); endproperty
    property p_gio_in;
        !rx_comp_enable |-> general_io_one_in == $past(rx_pin_level) && uart_rxd;
    endproperty
    property p_gio_idle; rx_comp_enable |-> !general_io_one_in; endproperty
    property p_tx_path;
        !$past(reset || sel_reg[7] || (cfg_reg[1] && !post))
            |-> optical_transmit_pin == $past(post);
    endproperty
    a_pls_fast: assert property (p_pls_fast) else $error("prompt pulse late");
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
    a_rx_uart: assert property (p_rx_uart) else $error("uart receive path wrong");
    a_rx_mode: assert property (p_rx_mode) else $error("receive mode wrong");
    a_rx_oe: assert property (p_rx_oe) else $error("receive pin enable wrong");
    a_gio_in: assert property (p_gio_in) else $error("general input wrong");
    a_gio_idle: assert property (p_gio_idle) else $error("general input not idle");
    a_tx_path: assert property (p_tx_path) else $error("transmit pin wrong");
endmodule
bind opcd_core opcd_core_monitor #(.CARRIER_DIV(CARRIER_DIV), .QW(QW)) opcd_core_monitor_i (
    .mclk(mclk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_comp_in(rx_comp_in),
    .rx_pin_level(rx_pin_level), .gio1_drive_en(gio1_drive_en),
    .rx_comp_enable(rx_comp_enable), .uart_rxd(uart_rxd),
    .general_io_one_in(general_io_one_in), .rx_pin_oe(rx_pin_oe), .uart_txd(uart_txd),
    .general_io_two(general_io_two), .optical_transmit_pin(optical_transmit_pin),
    .ce_real_issue(ce_real_issue), .real_energy_pulse(real_energy_pulse));

// file: opcd_xcvr_model.sv
// Optical far side: photodetector on the receive pin.
// Assumes light is a level from the bench; the pin has no pull resistor.
`timescale 1ns/1ns
module opcd_xcvr_model (
    input  logic light,
    input  logic pin_out,
    input  logic pin_oe,
    output logic comp,
    output logic level
);
    // Light pulls the detector low; a driving core wins the pin
    assign comp  = ~light;
    assign level = pin_oe ? pin_out : ~light;
endmodule

// file: opcd_core_tb.sv
// Self-checking bench for opcd_core with the optical far side model.
// Assumes the monitor is bound to the core; clock is 10 MHz.
`timescale 1ns/1ns
`define CHK(n, e, g) begin \
    num_checks++; \
    if ((g) !== (e)) begin \
        err_total++; \
        $display("Error %s expected %0h seen %0h", n, e, g); \
    end \
end
module opcd_core_tb;
    localparam int CDIV = 32;
    logic        mclk = 1'b0;
    logic        reset = 1'b1;
    logic [15:0] reg_addr = 16'h0000;
    logic [7:0]  reg_wdata = 8'h00;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic        light = 1'b0;
    logic        gio1_drive = 1'b0;
    logic        gio1_drive_en = 1'b0;
    logic        uart_txd = 1'b1;
    logic        general_io_two = 1'b0;
    logic        ce_real_issue = 1'b0;
    logic        ce_reactive_issue = 1'b0;
    logic [7:0]  reg_rdata;
    logic        rx_comp_in, rx_pin_level, rx_comp_enable, uart_rxd, general_io_one_in;
    logic        rx_pin_out, rx_pin_oe, optical_transmit_pin, real_energy_pulse;
    logic        reactive_energy_pulse;
    int          err_total = 0;
    int          num_checks = 0;
    opcd_core #(.CARRIER_DIV(CDIV), .QW(4)) opcd_core_i (
        .mclk(mclk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_comp_in(rx_comp_in),
        .rx_pin_level(rx_pin_level), .gio1_drive(gio1_drive), .gio1_drive_en(gio1_drive_en),
        .rx_comp_enable(rx_comp_enable), .uart_rxd(uart_rxd),
        .general_io_one_in(general_io_one_in), .rx_pin_out(rx_pin_out), .rx_pin_oe(rx_pin_oe),
        .uart_txd(uart_txd), .general_io_two(general_io_two),
        .optical_transmit_pin(optical_transmit_pin), .ce_real_issue(ce_real_issue),
        .ce_reactive_issue(ce_reactive_issue), .real_energy_pulse(real_energy_pulse),
        .reactive_energy_pulse(reactive_energy_pulse));
    opcd_xcvr_model opcd_xcvr_model_i (.light(light), .pin_out(rx_pin_out),
        .pin_oe(rx_pin_oe), .comp(rx_comp_in), .level(rx_pin_level));
    // Free-running clock
    always #50 mclk = ~mclk;
    // Register bus cycles and shared waits
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 `CHK("rdata", e, reg_rdata)
    endtask
    task automatic settle;
        repeat (3) @(posedge mclk);
        #1;
    endtask
    task automatic pls;
        @(posedge mclk);
        ce_real_issue     <= 1'b1;
        ce_reactive_issue <= 1'b1;
        @(posedge mclk);
        ce_real_issue     <= 1'b0;
        ce_reactive_issue <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic pin2(input logic e);
        #1 `CHK("real_pulse", e, real_energy_pulse)
        `CHK("reactive_pulse", e, reactive_energy_pulse)
    endtask
    // Reset values, readback, unused bits and an unmapped place
    task automatic t_regs;
        rd(16'h2004, 8'h00);
        rd(16'h2007, 8'h00);
        rd(16'h2008, 8'h00);
        rd(16'h2080, 8'hff);
        rd(16'h2081, 8'h00);
        wr(16'h2004, 8'hff);
        rd(16'h2004, 8'h40);
        wr(16'h2004, 8'h00);
        wr(16'h2000, 8'hff);
        rd(16'h2000, 8'h00);
    endtask
    // Receive pin in both modes, with and without inversion and drive
    task automatic t_rx;
        for (int i = 0; i < 8; i++) begin
            wr(16'h2008, {2'b00, i[2:1], 4'h0});
            light         <= i[0];
            gio1_drive_en <= i[0];
            gio1_drive    <= i[1];
            settle;
            if (i[2]) `CHK("gio_in", i[0] ? i[1] : 1'b1, general_io_one_in)
            else `CHK("uart_rxd", ~i[0] ^ i[1], uart_rxd)
            `CHK("rx_oe", i[2] & i[0], rx_pin_oe)
        end
        wr(16'h2008, 8'h00);
    endtask
    // Every transmit source, plain and inverted
    task automatic t_tx;
        logic exp;
        for (int i = 0; i < 16; i++) begin
            wr(16'h2007, {i[3:2], 6'h00});
            wr(16'h2008, {7'h00, i[1]});
            uart_txd       <= i[0];
            general_io_two <= ~i[0];
            settle;
            exp = (i[3] ? 1'b1 : (i[2] ? ~i[0] : i[0])) ^ i[1];
            `CHK("tx_pin", exp, optical_transmit_pin)
        end
    endtask
    // Carrier low time for every duty code
    task automatic t_car;
        int cnt;
        wr(16'h2007, 8'h00);
        wr(16'h2008, 8'h02);
        uart_txd <= 1'b1;
        settle;
        `CHK("tx_high", 1'b1, optical_transmit_pin)
        for (int d = 0; d < 4; d++) begin
            wr(16'h2007, {6'h00, d[1:0]});
            uart_txd <= 1'b0;
            settle;
            cnt = 0;
            repeat (CDIV) @(posedge mclk) #1 cnt += int'(!optical_transmit_pin);
            `CHK("carrier_low", CDIV >> (d + 1), cnt)
        end
        wr(16'h2008, 8'h00);
    endtask
    // Unpaced pulses: toggling, polarity and width limit
    task automatic t_fast;
        pls;
        pin2(1'b0);
        pls;
        pin2(1'b1);
        wr(16'h2004, 8'h40);
        settle;
        pin2(1'b0);
        pls;
        pin2(1'b1);
        pls;
        wr(16'h2004, 8'h00);
        wr(16'h2080, 8'h01);
        pls;
        repeat (3960) @(posedge mclk);
        pin2(1'b0);
        repeat (8000) @(posedge mclk);
        pin2(1'b1);
    endtask
    // Paced pulses wait for the interval tick
    task automatic t_paced;
        int n;
        wr(16'h2081, 8'h51);
        pls;
        rd(16'h2082, 8'h09);
        n = 0;
        while (real_energy_pulse !== 1'b0 && n < 4000) @(posedge mclk) #1 n++;
        `CHK("paced_wait", 1, int'(n > 0 && n < 4000))
        pin2(1'b0);
        rd(16'h2082, 8'hc0);
        repeat (12000) @(posedge mclk);
        pin2(1'b1);
        wr(16'h2081, 8'h00);
    endtask
    task automatic results;
        if (err_total == 0 && num_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // Main sequence after reset
    initial begin
        repeat (4) @(posedge mclk);
        reset <= 1'b0;
        t_regs;
        t_rx;
        t_tx;
        t_car;
        t_fast;
        t_paced;
        results;
    end
    // Watchdog at about twice the expected run
    initial begin
        repeat (60000) @(posedge mclk);
        err_total++;
        results;
    end
endmodule
